// ===== pkg/nmt_link_if.sv
// Link between a bus node and its far party.
`timescale 1ns/10ps
interface nmt_link_if;
   logic f2n_valid;
   logic f2n_tag;
   logic [nmt_pkg::PAY_W-1:0] f2n_payload;
   logic [nmt_pkg::SRC_W-1:0] f2n_src;
   logic n2f_valid;
   logic n2f_tag;
   logic [nmt_pkg::PAY_W-1:0] n2f_payload;
   logic pe_in_valid;
   logic pe_in_err;
   logic [nmt_pkg::PAY_W-1:0] pe_in_data;
   logic pe_in_pop;
   logic pe_out_valid;
   logic [nmt_pkg::PAY_W-1:0] pe_out_data;
   modport node (input f2n_valid, f2n_tag, f2n_payload, f2n_src, pe_in_valid, pe_in_err,
      pe_in_data, output n2f_valid, n2f_tag, n2f_payload, pe_in_pop, pe_out_valid, pe_out_data);
   modport far (output f2n_valid, f2n_tag, f2n_payload, f2n_src, pe_in_valid, pe_in_err,
      pe_in_data, input n2f_valid, n2f_tag, n2f_payload, pe_in_pop, pe_out_valid, pe_out_data);
endinterface

// ===== pkg/nmt_pkg.sv
// Shared constants and types for the node message timing block.
package nmt_pkg;
   // ---------------------------------------------------------------
   // Message format
   // ---------------------------------------------------------------
   localparam int PAY_W = 16;
   localparam logic TAG_DATA = 1'b0;
   localparam logic TAG_CTRL = 1'b1;
   localparam logic [PAY_W-1:0] LBL_INIT = 16'h0001;
   localparam logic [PAY_W-1:0] LBL_ECHO = 16'h0002;
   localparam int SRC_W = 2;
   localparam int NUM_SRC = 4;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int TIME_W = 16;
   localparam int CLK_NS = 20;
   localparam int NOMINAL_LINK_DELAY_NS = 200;
   localparam int RECEIVE_WINDOW_WIDTH_NS = 160;
   localparam int PROC_OFFSET_NS = 100;
   localparam int SYNC_DELAY_NS = 400;
   localparam int QUEUE_DELAY_NS = 600;
   localparam int MESSAGE_SPACING_NS = 400;
   localparam logic [TIME_W-1:0] NOMINAL_LINK_DELAY_CYC = TIME_W'(NOMINAL_LINK_DELAY_NS / CLK_NS);
   localparam logic [TIME_W-1:0] WIN_HALF_CYC = TIME_W'(RECEIVE_WINDOW_WIDTH_NS / (2 * CLK_NS));
   localparam logic [TIME_W-1:0] PROC_OFFSET_CYC = TIME_W'((PROC_OFFSET_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TIME_W-1:0] SYNC_DELAY_CYC = TIME_W'((SYNC_DELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TIME_W-1:0] QUEUE_DELAY_CYC = TIME_W'((QUEUE_DELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TIME_W-1:0] SPACING_CYC = TIME_W'((MESSAGE_SPACING_NS + CLK_NS - 1) / CLK_NS);
   // ---------------------------------------------------------------
   // Schedule
   // ---------------------------------------------------------------
   localparam int NUM_PORTS = 4;
   localparam int PORT_W = 2;
   localparam int CNT_W = 4;
   localparam int SUM_W = 8;
   localparam logic [SUM_W-1:0] SCHED_MAX_TOTAL = 8'h0c;
   localparam logic [CNT_W-1:0] DEFAULT_COUNT = 4'h1;
   typedef enum logic [1:0] {RX_TIMED, RX_FIXED, RX_QUEUE} nmt_rx_mode_t;
   typedef enum logic [1:0] {CTX_DIAG, CTX_SCHED, CTX_ACCUSE, CTX_BCAST} nmt_ctx_t;
endpackage

// ===== src/nmt_far.sv
// Far party: opposite-kind node transmitter and attached processing element.
`timescale 1ns/10ps
module nmt_far (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   nmt_link_if.far lnk,
   input wire logic tx_req_i,
   input wire logic tx_tag_i,
   input wire logic [nmt_pkg::PAY_W-1:0] tx_payload_i,
   input wire logic [nmt_pkg::SRC_W-1:0] tx_src_i,
   input wire logic pe_msg_i,
   input wire logic pe_err_i,
   input wire logic [nmt_pkg::PAY_W-1:0] pe_data_i,
   input wire logic sched_load_i,
   input wire logic [nmt_pkg::NUM_PORTS*nmt_pkg::CNT_W-1:0] sched_counts_i,
   output logic rx_valid_o,
   output logic rx_tag_o,
   output logic [nmt_pkg::PAY_W-1:0] rx_payload_o,
   output logic pe_rx_valid_o,
   output logic [nmt_pkg::PAY_W-1:0] pe_rx_data_o,
   output logic sched_busy_o
);
   logic sq_busy_r;
   logic [nmt_pkg::PORT_W-1:0] sq_idx_r;
   logic [nmt_pkg::TIME_W-1:0] sq_tmr_r;
   logic [nmt_pkg::NUM_PORTS*nmt_pkg::CNT_W-1:0] sq_cnt_r;
   logic sq_emit;

   assign sq_emit = sq_busy_r && (sq_tmr_r == '0);

   // ---------------------------------------------------------------
   // Broadcast transmitter
   // ---------------------------------------------------------------
   // R13: broadcast every transmission
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         lnk.f2n_valid <= 1'b0;
         lnk.f2n_tag <= nmt_pkg::TAG_DATA;
         lnk.f2n_payload <= '0;
         lnk.f2n_src <= '0;
      end else begin
         lnk.f2n_valid <= tx_req_i;
         lnk.f2n_tag <= tx_tag_i;
         lnk.f2n_payload <= tx_payload_i;
         lnk.f2n_src <= tx_src_i;
      end
   end

   // ---------------------------------------------------------------
   // Schedule sequencer
   // ---------------------------------------------------------------
   // R17: one message per port in order
   // R18: constant spacing between sends
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         sq_busy_r <= 1'b0;
         sq_idx_r <= '0;
         sq_tmr_r <= '0;
         sq_cnt_r <= '0;
      end else if (sched_load_i && !sq_busy_r) begin
         sq_busy_r <= 1'b1;
         sq_idx_r <= '0;
         sq_tmr_r <= '0;
         sq_cnt_r <= sched_counts_i;
      end else if (sq_emit) begin
         sq_tmr_r <= nmt_pkg::SPACING_CYC - 16'h0001;
         sq_idx_r <= sq_idx_r + 2'h1;
         sq_busy_r <= (sq_idx_r != nmt_pkg::PORT_W'(nmt_pkg::NUM_PORTS - 1));
      end else if (sq_tmr_r != '0) begin
         sq_tmr_r <= sq_tmr_r - 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Processing element input slot
   // ---------------------------------------------------------------
   // R14: message or error ready by fetch
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         lnk.pe_in_valid <= 1'b0;
         lnk.pe_in_err <= 1'b0;
         lnk.pe_in_data <= '0;
      end else if (sq_emit) begin
         lnk.pe_in_valid <= 1'b1;
         lnk.pe_in_err <= 1'b0;
         lnk.pe_in_data <= nmt_pkg::PAY_W'(sq_cnt_r[sq_idx_r*nmt_pkg::CNT_W +: nmt_pkg::CNT_W]);
      end else if (pe_msg_i || pe_err_i) begin
         lnk.pe_in_valid <= pe_msg_i && !pe_err_i;
         lnk.pe_in_err <= pe_err_i;
         lnk.pe_in_data <= pe_data_i;
      end else if (lnk.pe_in_pop) begin
         lnk.pe_in_valid <= 1'b0;
         lnk.pe_in_err <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Receive side
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         rx_valid_o <= 1'b0;
         rx_tag_o <= nmt_pkg::TAG_DATA;
         rx_payload_o <= '0;
         pe_rx_valid_o <= 1'b0;
         pe_rx_data_o <= '0;
         sched_busy_o <= 1'b0;
      end else begin
         rx_valid_o <= lnk.n2f_valid;
         rx_tag_o <= lnk.n2f_tag;
         rx_payload_o <= lnk.n2f_payload;
         pe_rx_valid_o <= lnk.pe_out_valid;
         pe_rx_data_o <= lnk.pe_out_data;
         sched_busy_o <= sq_busy_r;
      end
   end
endmodule

// ===== src/nmt_node.sv
// Bus node: receive timing disciplines, processing element slot fetch and schedule update.
//
// Functional notes
// R1: Message is one tag then payload.
// R2: Control tag selects labels, incl. init, echo.
// R3: Diagnosis data payload is Boolean node vector.
// R4: Schedule data payload is one port's count.
// R5: Accusation payloads use diagnostic vector format.
// R6: Timed receive accepts only inside centred window.
// R7: Valid timed message held until processing time.
// R8: Fixed-delay messages held a set duration.
// R9: Fixed delay only for init and echo.
// R10: Sync window may derive from local events.
// R11: Unsynchronized node queues, processes in order.
// R12: Queue delay separate from sync delay.
// R13: Broadcast always; capture regardless of mode. Node drops tx_req_i when pe_fetch_i is high.
// R14: Element presents message or error in time.
// R15: Output written to element without ready.
// R16: Diagnosis convictions stored and forwarded.
// R17: Element sends schedule one port per message.
// R18: Schedule messages sent at constant spacing.
// R19: One schedule iteration per port.
// R20: Iteration result returned in second step.
// R21: Check schedule; else adopt default.
// R22: Grant ports ascending, skip empty ones.
// R23: One-bit tag; window bounds inclusive.
// R24: Bad reception sets per-source error flag.
`timescale 1ns/10ps
module nmt_node #(
   parameter int DEPTH = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   nmt_link_if.node lnk,
   input wire nmt_pkg::nmt_rx_mode_t rx_mode_i,
   input wire nmt_pkg::nmt_ctx_t ctx_i,
   input wire logic tt_arm_i,
   input wire logic [nmt_pkg::TIME_W-1:0] send_time_i,
   input wire logic local_event_i,
   input wire logic sync_window_en_i,
   input wire logic tx_req_i,
   input wire logic tx_tag_i,
   input wire logic [nmt_pkg::PAY_W-1:0] tx_payload_i,
   input wire logic pe_fetch_i,
   input wire logic [nmt_pkg::NUM_SRC-1:0] err_clr_i,
   output logic [nmt_pkg::TIME_W-1:0] local_time_o,
   output logic proc_valid_o,
   output logic proc_tag_o,
   output logic [nmt_pkg::PAY_W-1:0] proc_payload_o,
   output logic [nmt_pkg::SRC_W-1:0] proc_src_o,
   output logic [nmt_pkg::NUM_SRC-1:0] err_flag_o,
   output logic pe_err_o,
   output logic [nmt_pkg::PAY_W-1:0] conviction_o,
   output logic sched_done_o,
   output logic sched_default_o,
   output logic grant_valid_o,
   output logic [nmt_pkg::PORT_W-1:0] grant_port_o
);
   localparam int TW = nmt_pkg::TIME_W;
   localparam int PW = nmt_pkg::PAY_W;
   localparam int SW = nmt_pkg::SRC_W;
   localparam int CW = nmt_pkg::CNT_W;
   localparam int QW = $clog2(DEPTH);
   localparam int ENT_W = 1 + PW + SW + TW;

   logic [TW-1:0] lt_r;
   logic tt_armed_r, tt_full_r, fx_full_r, sx_armed_r;
   logic [TW-1:0] tt_exp_r, sx_exp_r, fx_due_r;
   logic [1+PW+SW-1:0] tt_ent_r, fx_ent_r, out_ent;
   logic [ENT_W-1:0] q_mem [DEPTH];
   logic [QW-1:0] q_rd_r, q_wr_r;
   logic [QW:0] q_cnt_r;
   logic arr, is_sync, in_tt, in_sx, tt_due, tt_acc, fx_acc, q_acc, bad;
   logic tt_rel, fx_rel, q_rel, out_data;
   logic [nmt_pkg::PORT_W-1:0] it_r, g_port_r;
   logic [CW-1:0] sched_r [nmt_pkg::NUM_PORTS];
   logic [CW-1:0] active_r [nmt_pkg::NUM_PORTS];
   logic res_pend_r, chk_r, g_busy_r;
   logic [CW-1:0] g_left_r;
   logic [TW-1:0] g_tmr_r;
   logic [nmt_pkg::SUM_W-1:0] sum;

   // Wrap-safe test that the time base has reached the mark.
   function automatic logic reached(input logic [TW-1:0] now, input logic [TW-1:0] mark);
      logic [TW-1:0] d;
      d = now - mark;
      return !d[TW-1];
   endfunction

   // ---------------------------------------------------------------
   // Local time base
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         lt_r <= '0;
         local_time_o <= '0;
      end else begin
         lt_r <= lt_r + 16'h0001;
         local_time_o <= lt_r + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Arrival classification
   // ---------------------------------------------------------------
   // R13: capture in every mode
   assign arr = lnk.f2n_valid;
   // R2: label decode on control tag
   assign is_sync = (lnk.f2n_tag == nmt_pkg::TAG_CTRL) &&
      (lnk.f2n_payload == nmt_pkg::LBL_INIT || lnk.f2n_payload == nmt_pkg::LBL_ECHO);
   // R23: inclusive window bounds
   assign in_tt = (lt_r - (tt_exp_r - nmt_pkg::WIN_HALF_CYC)) <= 2 * nmt_pkg::WIN_HALF_CYC;
   assign in_sx = (lt_r - (sx_exp_r - nmt_pkg::WIN_HALF_CYC)) <= 2 * nmt_pkg::WIN_HALF_CYC;
   assign tt_due = tt_armed_r && (lt_r == tt_exp_r + nmt_pkg::PROC_OFFSET_CYC);
   // R6: accept only inside the window
   assign tt_acc = arr && rx_mode_i == nmt_pkg::RX_TIMED && tt_armed_r && !tt_full_r && in_tt;
   // R9: fixed delay for sync labels only
   // R10: optional window from local event
   assign fx_acc = arr && rx_mode_i == nmt_pkg::RX_FIXED && is_sync && !fx_full_r &&
      (!sync_window_en_i || (sx_armed_r && in_sx));
   assign q_acc = arr && rx_mode_i == nmt_pkg::RX_QUEUE && q_cnt_r != (QW+1)'(DEPTH);
   assign bad = arr && !tt_acc && !fx_acc && !q_acc;

   // ---------------------------------------------------------------
   // Hold buffers
   // ---------------------------------------------------------------
   assign tt_rel = tt_due && tt_full_r;
   assign fx_rel = fx_full_r && reached(lt_r, fx_due_r) && !tt_rel;
   assign q_rel = q_cnt_r != '0 && reached(lt_r, q_mem[q_rd_r][TW-1:0]) && !tt_rel && !fx_full_r;

   // R7: hold until processing time
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         tt_armed_r <= 1'b0;
         tt_full_r <= 1'b0;
         tt_exp_r <= '0;
         tt_ent_r <= '0;
      end else begin
         if (tt_arm_i) begin
            tt_armed_r <= 1'b1;
            tt_full_r <= 1'b0;
            tt_exp_r <= send_time_i + nmt_pkg::NOMINAL_LINK_DELAY_CYC;
         end else if (tt_due) begin
            tt_armed_r <= 1'b0;
            tt_full_r <= 1'b0;
         end else if (tt_acc) begin
            tt_full_r <= 1'b1;
            tt_ent_r <= {lnk.f2n_tag, lnk.f2n_payload, lnk.f2n_src};
         end
      end
   end

   // R8: fixed-delay hold
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         fx_full_r <= 1'b0;
         fx_due_r <= '0;
         fx_ent_r <= '0;
         sx_armed_r <= 1'b0;
         sx_exp_r <= '0;
      end else begin
         if (local_event_i) begin
            sx_armed_r <= 1'b1;
            sx_exp_r <= lt_r + nmt_pkg::NOMINAL_LINK_DELAY_CYC;
         end
         if (fx_acc) begin
            fx_full_r <= 1'b1;
            fx_due_r <= lt_r + nmt_pkg::SYNC_DELAY_CYC;
            fx_ent_r <= {lnk.f2n_tag, lnk.f2n_payload, lnk.f2n_src};
         end else if (fx_rel) begin
            fx_full_r <= 1'b0;
         end
      end
   end

   // R11: arrival-order queue
   // R12: own queue delay
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         q_rd_r <= '0;
         q_wr_r <= '0;
         q_cnt_r <= '0;
      end else begin
         if (q_acc) begin
            q_mem[q_wr_r] <= {lnk.f2n_tag, lnk.f2n_payload, lnk.f2n_src,
               lt_r + nmt_pkg::QUEUE_DELAY_CYC};
            q_wr_r <= q_wr_r + QW'(1);
         end
         if (q_rel) begin
            q_rd_r <= q_rd_r + QW'(1);
         end
         q_cnt_r <= q_cnt_r + (QW+1)'(q_acc) - (QW+1)'(q_rel);
      end
   end

   // ---------------------------------------------------------------
   // Processing output and errors
   // ---------------------------------------------------------------
   assign out_ent = tt_rel ? tt_ent_r : (fx_rel ? fx_ent_r : q_mem[q_rd_r][ENT_W-1:TW]);
   assign out_data = tt_rel && tt_ent_r[PW+SW] == nmt_pkg::TAG_DATA;

   // R5: accusations keep vector layout
   // R1: tag then payload unpacking
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         proc_valid_o <= 1'b0;
         proc_tag_o <= nmt_pkg::TAG_DATA;
         proc_payload_o <= '0;
         proc_src_o <= '0;
      end else begin
         proc_valid_o <= tt_rel || fx_rel || q_rel;
         {proc_tag_o, proc_payload_o, proc_src_o} <= out_ent;
      end
   end

   // R24: per-source flags, set beats clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         err_flag_o <= '0;
      end else begin
         err_flag_o <= (err_flag_o & ~err_clr_i) |
            (bad ? (nmt_pkg::NUM_SRC'(1) << lnk.f2n_src) : '0);
      end
   end

   // ---------------------------------------------------------------
   // Transmit and processing element input
   // ---------------------------------------------------------------
   assign lnk.pe_in_pop = pe_fetch_i;

   // R13: broadcast to opposite nodes
   // R14: missing element message is an error
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         lnk.n2f_valid <= 1'b0;
         lnk.n2f_tag <= nmt_pkg::TAG_DATA;
         lnk.n2f_payload <= '0;
         pe_err_o <= 1'b0;
      end else begin
         lnk.n2f_valid <= (pe_fetch_i && lnk.pe_in_valid) || (!pe_fetch_i && tx_req_i);
         lnk.n2f_tag <= pe_fetch_i ? nmt_pkg::TAG_DATA : tx_tag_i;
         lnk.n2f_payload <= pe_fetch_i ? lnk.pe_in_data : tx_payload_i;
         pe_err_o <= pe_err_o || (pe_fetch_i && (lnk.pe_in_err || !lnk.pe_in_valid));
      end
   end

   // ---------------------------------------------------------------
   // Diagnosis and schedule agreement
   // ---------------------------------------------------------------
   always_comb begin
      sum = '0;
      for (int i = 0; i < nmt_pkg::NUM_PORTS; i++) begin
         sum = sum + nmt_pkg::SUM_W'(sched_r[i]);
      end
   end

   // R16: store and forward convictions
   // R3: payload as node vector
   // R4: payload as port count
   // R19: one iteration per port
   // R20: result out in second step
   // R15: element output without ready
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         conviction_o <= '0;
         it_r <= '0;
         res_pend_r <= 1'b0;
         chk_r <= 1'b0;
         lnk.pe_out_valid <= 1'b0;
         lnk.pe_out_data <= '0;
         for (int i = 0; i < nmt_pkg::NUM_PORTS; i++) begin
            sched_r[i] <= '0;
         end
      end else begin
         lnk.pe_out_valid <= 1'b0;
         chk_r <= 1'b0;
         res_pend_r <= 1'b0;
         if (res_pend_r) begin
            lnk.pe_out_valid <= 1'b1;
            lnk.pe_out_data <= PW'(sched_r[it_r]);
            it_r <= it_r + 2'h1;
            chk_r <= (it_r == nmt_pkg::PORT_W'(nmt_pkg::NUM_PORTS - 1));
         end else if (out_data && ctx_i == nmt_pkg::CTX_DIAG) begin
            conviction_o <= tt_ent_r[PW+SW-1:SW];
            lnk.pe_out_valid <= 1'b1;
            lnk.pe_out_data <= tt_ent_r[PW+SW-1:SW];
         end else if (out_data && ctx_i == nmt_pkg::CTX_SCHED) begin
            sched_r[it_r] <= tt_ent_r[SW +: CW];
            res_pend_r <= 1'b1;
         end
      end
   end

   // R21: validate or use default
   // R22: ascending grants, empty ports skipped
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         sched_done_o <= 1'b0;
         sched_default_o <= 1'b0;
         g_busy_r <= 1'b0;
         g_port_r <= '0;
         g_left_r <= '0;
         g_tmr_r <= '0;
         grant_valid_o <= 1'b0;
         grant_port_o <= '0;
         for (int i = 0; i < nmt_pkg::NUM_PORTS; i++) begin
            active_r[i] <= nmt_pkg::DEFAULT_COUNT;
         end
      end else begin
         sched_done_o <= chk_r;
         grant_valid_o <= 1'b0;
         if (chk_r) begin
            sched_default_o <= sum > nmt_pkg::SCHED_MAX_TOTAL;
            for (int i = 0; i < nmt_pkg::NUM_PORTS; i++) begin
               active_r[i] <= (sum > nmt_pkg::SCHED_MAX_TOTAL) ? nmt_pkg::DEFAULT_COUNT
                  : sched_r[i];
            end
            g_busy_r <= 1'b1;
            g_port_r <= '0;
            g_left_r <= '0;
            g_tmr_r <= '0;
         end else if (g_busy_r) begin
            if (g_tmr_r != '0) begin
               g_tmr_r <= g_tmr_r - 16'h0001;
            end
            if (g_left_r != '0 && g_tmr_r == '0) begin
               grant_valid_o <= 1'b1;
               grant_port_o <= g_port_r;
               g_left_r <= g_left_r - 4'h1;
               g_tmr_r <= nmt_pkg::SPACING_CYC - 16'h0001;
            end else if (g_left_r == '0) begin
               if (grant_valid_o || g_tmr_r != '0 || active_r[g_port_r] != '0) begin
                  g_left_r <= grant_valid_o ? '0 : active_r[g_port_r];
               end
               if (grant_valid_o || active_r[g_port_r] == '0) begin
                  g_busy_r <= g_port_r != nmt_pkg::PORT_W'(nmt_pkg::NUM_PORTS - 1);
                  g_port_r <= g_port_r + 2'h1;
               end
            end
         end
      end
   end
endmodule

// ===== test/nmt_assertions.sv
// Concurrent checks on the link joining a bus node to its far party.
`timescale 1ns/10ps
module nmt_assertions (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic f2n_valid,
   input wire logic pe_in_valid,
   input wire logic pe_in_err,
   input wire logic [nmt_pkg::PAY_W-1:0] pe_in_data,
   input wire logic pe_in_pop,
   input wire logic n2f_valid,
   input wire logic [nmt_pkg::PAY_W-1:0] n2f_payload,
   input wire logic pe_out_valid
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // ---------------------------------------------------------------
   // Slot fetch steps
   // ---------------------------------------------------------------
   sequence fetch_full_s;
      pe_in_pop && pe_in_valid;
   endsequence
   sequence fetch_empty_s;
      pe_in_pop && !pe_in_valid;
   endsequence
   fetch_send_a: assert property (
      fetch_full_s |=> n2f_valid && n2f_payload == $past(pe_in_data))
      else $error("fetched slot not broadcast");
   fetch_empty_a: assert property (
      fetch_empty_s |=> !n2f_valid) else $error("empty slot broadcast");
   pop_clear_a: assert property (
      pe_in_pop |-> ##1 !pe_in_valid && !pe_in_err) else $error("slot kept after pop");
   slot_hold_a: assert property (
      pe_in_valid && !pe_in_pop |=> pe_in_valid) else $error("slot dropped before pop");
   err_hold_a: assert property (
      pe_in_err && !pe_in_pop |=> pe_in_err) else $error("error indication dropped");
   out_pulse_a: assert property (
      pe_out_valid |=> !pe_out_valid) else $error("element output longer than a cycle");
   node_reset_a: assert property (
      $rose(rst_b_i) |-> !n2f_valid && !pe_out_valid) else $error("node output after reset");
   far_reset_a: assert property (
      $rose(rst_b_i) |-> !f2n_valid && !pe_in_valid && !pe_in_err)
      else $error("far output after reset");
endmodule

// ===== test/tb.sv
// Self-checking bench joining a bus node to its far party.
`timescale 1ns/10ps
module tb;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   nmt_pkg::nmt_rx_mode_t rx_mode = nmt_pkg::RX_TIMED;
   nmt_pkg::nmt_ctx_t ctx = nmt_pkg::CTX_DIAG;
   logic arm = 1'b0, ntx = 1'b0, ntag = 1'b0, ftx = 1'b0, ftag = 1'b0, fetch = 1'b0;
   logic pmsg = 1'b0, perr = 1'b0, sload = 1'b0;
   logic [15:0] stime = 16'h0000, npay = 16'h0000, fpay = 16'h0000, pdata = 16'h0000;
   logic [15:0] scnt = 16'h0000, ltime, ppay, rpay, prdata, conv;
   logic [3:0] eclr = 4'h0, eflag;
   logic [1:0] fsrc = 2'h0, psrc, gport;
   logic pv, ptag, rv, rtag, prv, sbusy, pe_err, sdone, sdef, gv;
   logic [31:0] sq[$], xq[$], v;
   int n_fail = 0, n_compared = 0, seed = 37, offs[5] = '{-5, -4, 0, 4, 5}, tot;
   nmt_link_if lnk ();
   nmt_node i_nmt_node (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .lnk(lnk), .rx_mode_i(rx_mode),
      .ctx_i(ctx), .tt_arm_i(arm), .send_time_i(stime), .local_event_i(1'b0),
      .sync_window_en_i(1'b0), .tx_req_i(ntx), .tx_tag_i(ntag), .tx_payload_i(npay),
      .pe_fetch_i(fetch), .err_clr_i(eclr), .local_time_o(ltime), .proc_valid_o(pv),
      .proc_tag_o(ptag), .proc_payload_o(ppay), .proc_src_o(psrc), .err_flag_o(eflag),
      .pe_err_o(pe_err), .conviction_o(conv), .sched_done_o(sdone), .sched_default_o(sdef),
      .grant_valid_o(gv), .grant_port_o(gport));
   nmt_far i_nmt_far (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .lnk(lnk), .tx_req_i(ftx),
      .tx_tag_i(ftag), .tx_payload_i(fpay), .tx_src_i(fsrc), .pe_msg_i(pmsg), .pe_err_i(perr),
      .pe_data_i(pdata), .sched_load_i(sload), .sched_counts_i(scnt), .rx_valid_o(rv),
      .rx_tag_o(rtag), .rx_payload_o(rpay), .pe_rx_valid_o(prv), .pe_rx_data_o(prdata),
      .sched_busy_o(sbusy));
   nmt_assertions u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .f2n_valid(lnk.f2n_valid),
      .pe_in_valid(lnk.pe_in_valid), .pe_in_err(lnk.pe_in_err), .pe_in_data(lnk.pe_in_data),
      .pe_in_pop(lnk.pe_in_pop), .n2f_valid(lnk.n2f_valid), .n2f_payload(lnk.n2f_payload),
      .pe_out_valid(lnk.pe_out_valid));
   initial begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // One ordered log of results, so order faults show as mismatches.
   always @(posedge sys_clk_i) begin
      if (pv && ctx != nmt_pkg::CTX_SCHED) sq.push_back({8'h01, 5'h00, ptag, psrc, ppay});
      if (prv) sq.push_back({8'h03, 8'h00, prdata});
      if (gv) sq.push_back({8'h02, 22'h000000, gport});
      if (rv) sq.push_back({8'h04, 7'h00, rtag, rpay});
   end
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic settle();
      int i;
      for (i = 0; i < 600 && sq.size() < xq.size(); i++) @(negedge sys_clk_i);
      if (i == 600) begin
         n_fail++;
         end_of_test();
      end
      repeat (40) @(negedge sys_clk_i);
      chk("event count", sq.size(), xq.size());
      for (i = 0; i < xq.size() && i < sq.size(); i++) chk("event", sq[i], xq[i]);
      sq.delete();
      xq.delete();
   endtask
   task automatic fsend(input logic tag, input logic [15:0] pay, input logic [1:0] src);
      ftx = 1'b1;
      ftag = tag;
      fpay = pay;
      fsrc = src;
      @(negedge sys_clk_i);
      ftx = 1'b0;
   endtask
   // Arrival lands off cycles from the armed expected time.
   task automatic timed(input int off, input logic [15:0] pay, input logic [1:0] src);
      arm = 1'b1;
      stime = ltime;
      @(negedge sys_clk_i);
      arm = 1'b0;
      repeat (8 + off) @(negedge sys_clk_i);
      fsend(nmt_pkg::TAG_DATA, pay, src);
   endtask
   task automatic one(input logic ok, input logic tag, input logic [1:0] s, input logic [15:0] p);
      if (ok) xq.push_back({8'h01, 5'h00, tag, s, p});
      if (ok && ctx == nmt_pkg::CTX_DIAG) xq.push_back({8'h03, 8'h00, p});
      settle();
      chk("error flag", eflag[s], !ok);
      eclr[s] = 1'b1;
      @(negedge sys_clk_i);
      eclr = 4'h0;
   endtask
   initial begin
      repeat (12) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      foreach (offs[j]) begin
         v = $random(seed);
         timed(offs[j], v[15:0], v[17:16]);
         one(offs[j] * offs[j] <= 16, nmt_pkg::TAG_DATA, v[17:16], v[15:0]);
         if (offs[j] == 0) chk("conviction", conv, v[15:0]);
      end
      rx_mode = nmt_pkg::RX_FIXED;
      ctx = nmt_pkg::CTX_BCAST;
      for (int j = 0; j < 4; j++) begin
         v = j == 0 ? nmt_pkg::LBL_INIT : j == 1 ? nmt_pkg::LBL_ECHO : 16'h0003;
         fsend(j < 3, v[15:0], 2'h1);
         one(j < 2, j < 3, 2'h1, v[15:0]);
      end
      rx_mode = nmt_pkg::RX_QUEUE;
      ctx = nmt_pkg::CTX_ACCUSE;
      ftx = 1'b1;
      for (int j = 0; j < 3; j++) begin
         v = $random(seed);
         {fsrc, fpay} = v[17:0];
         xq.push_back({8'h01, 6'h00, v[17:0]});
         @(negedge sys_clk_i);
      end
      ftx = 1'b0;
      settle();
      v = $random(seed);
      pdata = v[15:0];
      pmsg = 1'b1;
      @(negedge sys_clk_i);
      pmsg = 1'b0;
      fetch = 1'b1;
      @(negedge sys_clk_i);
      fetch = 1'b0;
      {ntx, ntag, npay} = {2'h3, nmt_pkg::LBL_ECHO};
      @(negedge sys_clk_i);
      ntx = 1'b0;
      xq.push_back({8'h04, 8'h00, v[15:0]});
      xq.push_back({8'h04, 7'h00, 1'b1, nmt_pkg::LBL_ECHO});
      perr = 1'b1;
      @(negedge sys_clk_i);
      perr = 1'b0;
      @(negedge sys_clk_i);
      fetch = 1'b1;
      @(negedge sys_clk_i);
      fetch = 1'b0;
      settle();
      chk("element error", pe_err, 1'b1);
      rx_mode = nmt_pkg::RX_TIMED;
      ctx = nmt_pkg::CTX_SCHED;
      for (int r = 0; r < 2; r++) begin
         v = $random(seed);
         scnt = r == 0 ? v[15:0] & 16'h3333 : v[15:0] | 16'h8888;
         sload = 1'b1;
         @(negedge sys_clk_i);
         sload = 1'b0;
         tot = scnt[3:0] + scnt[7:4] + scnt[11:8] + scnt[15:12];
         for (int p = 0; p < 4; p++) begin
            timed(0, {12'h000, scnt[p*4+:4]}, 2'h0);
            repeat (10) @(negedge sys_clk_i);
            xq.push_back({8'h03, 20'h00000, scnt[p*4+:4]});
         end
         for (int p = 0; p < 4; p++) begin
            repeat (tot > 12 ? 1 : scnt[p*4+:4]) xq.push_back({8'h02, 22'h000000, p[1:0]});
         end
         settle();
         chk("default", sdef, tot > 12);
         chk("busy", sbusy, 1'b0);
      end
      end_of_test();
   end
endmodule
